// *** rtl/gtc_cfg.svh ***
// Offsets, field positions, reset values and legal entry range of the pin trigger block
`ifndef GTC_CFG_SVH
`define GTC_CFG_SVH

// Register offsets
`define GTC_ADDR_PIN_CTRL   8'h05
`define GTC_ADDR_CONV_CFG   8'h06
`define GTC_ADDR_SEQ_ENTRY  8'h07

// Field positions
`define GTC_DIR_HI          7
`define GTC_DIR_LO          6
`define GTC_ISEL_HI         5
`define GTC_ISEL_LO         4
`define GTC_OSEL_HI         2
`define GTC_OSEL_LO         0
`define GTC_DEST_HI         6
`define GTC_DEST_LO         4
`define GTC_KIND_HI         1
`define GTC_KIND_LO         0
`define GTC_ENTRY_HI        6
`define GTC_ENTRY_LO        0

// Reset values
`define GTC_RST_DIR         2'h0
`define GTC_RST_ISEL        2'h0
`define GTC_RST_OSEL        3'h0
`define GTC_RST_DEST        3'h0
`define GTC_RST_KIND        2'h0
`define GTC_RST_ENTRY       7'h3a

// Legal sequence entry range
`define GTC_ENTRY_MIN       7'h3a
`define GTC_ENTRY_MAX       7'h6f

`endif

// *** rtl/gtc_pkg.sv ***
// Types of the pin trigger configuration block
package gtc_pkg;

  typedef enum logic [1:0] {
    GTC_DIR_INPUT = 2'h0,
    GTC_DIR_RSVD  = 2'h1,
    GTC_DIR_OPEN  = 2'h2,
    GTC_DIR_CMOS  = 2'h3
  } gtc_dir_t;

  typedef enum logic [1:0] {
    GTC_IN_OFF  = 2'h0,
    GTC_IN_CONV = 2'h1,
    GTC_IN_SEQ  = 2'h2,
    GTC_IN_RSVD = 2'h3
  } gtc_isel_t;

  typedef enum logic [2:0] {
    GTC_OUT_HIZ  = 3'h0,
    GTC_OUT_IRQN = 3'h1,
    GTC_OUT_IRQ  = 3'h2,
    GTC_OUT_LOW  = 3'h3,
    GTC_OUT_HIGH = 3'h4,
    GTC_OUT_CLK  = 3'h5,
    GTC_OUT_MOD  = 3'h6,
    GTC_OUT_LSW  = 3'h7
  } gtc_osel_t;

  typedef enum logic [1:0] {
    GTC_PWR_NORMAL  = 2'h0,
    GTC_PWR_STANDBY = 2'h1,
    GTC_PWR_SLEEP   = 2'h2
  } gtc_pwr_t;

  typedef enum logic [1:0] {
    GTC_FSM_IDLE = 2'h0,
    GTC_FSM_WAKE = 2'h1
  } gtc_fsm_t;

  // Settings handed to the converter and sequencer
  typedef struct packed {
    logic [2:0] dest;
    logic [1:0] kind;
    logic [6:0] entry;
  } gtc_trig_cfg_t;

  // Whole module state
  typedef struct packed {
    gtc_dir_t      dir;
    gtc_isel_t     isel;
    gtc_osel_t     osel;
    gtc_trig_cfg_t cfg;
    logic          sync1;
    logic          sync2;
    logic          prev;
    gtc_fsm_t      fsm;
    logic          pend_seq;
    logic          wake;
    logic          conv_go;
    logic          seq_go;
    logic          pin_o;
    logic          pin_oe;
    logic          clk_tgl;
    logic [7:0]    rdata;
  } gtc_state_t;

endpackage

// *** rtl/gtc_top.sv ***
// Second general-purpose pin: configuration, output drive and edge trigger
`timescale 1ns/1ns
`include "gtc_cfg.svh"

module gtc_top
  import gtc_pkg::*;
(
  input  wire logic       CLOCK_IN,
  input  wire logic       RST_IN,
  input  wire logic       REG_WR_IN,
  input  wire logic [7:0] REG_ADDR_IN,
  input  wire logic [7:0] REG_WDATA_IN,
  output logic      [7:0] REG_RDATA_OUT,
  input  wire logic       PIN_IN,
  output logic            PIN_OUT,
  output logic            PIN_OE_OUT,
  input  wire logic       IRQ_IN,
  input  wire logic       MOD_ACTIVE_IN,
  input  wire logic       LOW_SIDE_SW_IN,
  input  wire logic [1:0] POWER_STATE_IN,
  output logic            WAKE_REQ_OUT,
  output logic            CONV_START_OUT,
  output logic            SEQ_START_OUT,
  output logic      [2:0] RESULT_TARGET_OUT,
  output logic      [1:0] CONV_KIND_OUT,
  output logic      [6:0] SEQ_ENTRY_OUT
);

  gtc_state_t st_reg;
  gtc_state_t st_next;

  // Decoded write strobes and field views of the write data
  logic       wr_ctrl;
  logic       wr_conv;
  logic       wr_entry;
  logic [1:0] w_dir;
  logic [1:0] w_isel;
  logic [2:0] w_osel;
  logic [6:0] w_entry;
  logic       ctrl_ok;
  logic       entry_ok;
  logic       rise;
  logic       trig_en;
  logic       asleep;

  assign wr_ctrl  = REG_WR_IN && (REG_ADDR_IN == `GTC_ADDR_PIN_CTRL);
  assign wr_conv  = REG_WR_IN && (REG_ADDR_IN == `GTC_ADDR_CONV_CFG);
  assign wr_entry = REG_WR_IN && (REG_ADDR_IN == `GTC_ADDR_SEQ_ENTRY);
  assign w_dir    = REG_WDATA_IN[`GTC_DIR_HI:`GTC_DIR_LO];
  assign w_isel   = REG_WDATA_IN[`GTC_ISEL_HI:`GTC_ISEL_LO];
  assign w_osel   = REG_WDATA_IN[`GTC_OSEL_HI:`GTC_OSEL_LO];
  assign w_entry  = REG_WDATA_IN[`GTC_ENTRY_HI:`GTC_ENTRY_LO];

  // Reserved codes reject the whole byte so fields never disagree
  assign ctrl_ok  = (w_dir != GTC_DIR_RSVD) && (w_isel != GTC_IN_RSVD);

  // Out-of-range entry points would run into non-microcode space
  assign entry_ok = (w_entry >= `GTC_ENTRY_MIN) && (w_entry <= `GTC_ENTRY_MAX);

  // Edge from the second and third stage only, never the first flop
  assign rise     = st_reg.sync2 && !st_reg.prev;

  // Trigger path live only while the pin is an input
  assign trig_en  = (st_reg.dir == GTC_DIR_INPUT) && (st_reg.isel != GTC_IN_OFF);
  assign asleep   = (POWER_STATE_IN != GTC_PWR_NORMAL);

  // Next state of everything
  always_comb begin
    st_next         = st_reg;
    st_next.conv_go = 1'b0;
    st_next.seq_go  = 1'b0;
    st_next.sync1   = PIN_IN;
    st_next.sync2   = st_reg.sync1;
    st_next.prev    = st_reg.sync2;
    st_next.clk_tgl = !st_reg.clk_tgl;

    // Register writes store settings only; starts come from the pin
    if (wr_ctrl && ctrl_ok) begin
      st_next.dir  = gtc_dir_t'(w_dir);
      st_next.isel = gtc_isel_t'(w_isel);
      st_next.osel = gtc_osel_t'(w_osel);
    end
    if (wr_conv) begin
      st_next.cfg.dest = REG_WDATA_IN[`GTC_DEST_HI:`GTC_DEST_LO];
      st_next.cfg.kind = REG_WDATA_IN[`GTC_KIND_HI:`GTC_KIND_LO];
    end
    if (wr_entry && entry_ok) begin
      st_next.cfg.entry = w_entry;
    end

    // Trigger sequencing; a wake must finish before any start
    case (st_reg.fsm)
      GTC_FSM_IDLE: begin
        if (rise && trig_en) begin
          st_next.pend_seq = (st_reg.isel == GTC_IN_SEQ);
          if (asleep) begin
            st_next.wake = 1'b1;
            st_next.fsm  = GTC_FSM_WAKE;
          end else if (st_reg.isel == GTC_IN_SEQ) begin
            st_next.seq_go = 1'b1;
          end else begin
            st_next.conv_go = 1'b1;
          end
        end
      end
      GTC_FSM_WAKE: begin
        // Further edges are absorbed while waiting for normal power
        if (!asleep) begin
          st_next.wake    = 1'b0;
          st_next.fsm     = GTC_FSM_IDLE;
          st_next.seq_go  = st_reg.pend_seq;
          st_next.conv_go = !st_reg.pend_seq;
        end
      end
      default: begin
        st_next.fsm  = GTC_FSM_IDLE;
        st_next.wake = 1'b0;
      end
    endcase

    // Pin drive; output function ignored while direction is input
    st_next.pin_o  = 1'b0;
    st_next.pin_oe = 1'b0;
    if (st_reg.dir == GTC_DIR_OPEN || st_reg.dir == GTC_DIR_CMOS) begin
      case (st_reg.osel)
        GTC_OUT_HIZ:  st_next.pin_o = 1'b0;
        GTC_OUT_IRQN: st_next.pin_o = !IRQ_IN;
        GTC_OUT_IRQ:  st_next.pin_o = IRQ_IN;
        GTC_OUT_LOW:  st_next.pin_o = 1'b0;
        GTC_OUT_HIGH: st_next.pin_o = 1'b1;
        GTC_OUT_CLK:  st_next.pin_o = st_reg.clk_tgl;
        GTC_OUT_MOD:  st_next.pin_o = MOD_ACTIVE_IN;
        GTC_OUT_LSW:  st_next.pin_o = 1'b0;
        default:      st_next.pin_o = 1'b0;
      endcase
      if (st_reg.osel == GTC_OUT_HIZ) begin
        st_next.pin_oe = 1'b0;
      end else if (st_reg.osel == GTC_OUT_LSW) begin
        st_next.pin_oe = LOW_SIDE_SW_IN;
      end else if (st_reg.dir == GTC_DIR_OPEN) begin
        st_next.pin_oe = !st_next.pin_o;
      end else begin
        st_next.pin_oe = 1'b1;
      end
    end

    // Read mux; reserved bits and unmapped offsets read zero
    case (REG_ADDR_IN)
      `GTC_ADDR_PIN_CTRL:  st_next.rdata = {st_reg.dir, st_reg.isel, 1'b0, st_reg.osel};
      `GTC_ADDR_CONV_CFG:  st_next.rdata = {1'b0, st_reg.cfg.dest, 2'h0, st_reg.cfg.kind};
      `GTC_ADDR_SEQ_ENTRY: st_next.rdata = {1'b0, st_reg.cfg.entry};
      default:             st_next.rdata = 8'h00;
    endcase
  end

  // State register; constants only under reset
  always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      st_reg           <= '0;
      st_reg.dir       <= gtc_dir_t'(`GTC_RST_DIR);
      st_reg.isel      <= gtc_isel_t'(`GTC_RST_ISEL);
      st_reg.osel      <= gtc_osel_t'(`GTC_RST_OSEL);
      st_reg.cfg.dest  <= `GTC_RST_DEST;
      st_reg.cfg.kind  <= `GTC_RST_KIND;
      st_reg.cfg.entry <= `GTC_RST_ENTRY;
      st_reg.fsm       <= GTC_FSM_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  // Every output straight from a flop
  assign REG_RDATA_OUT     = st_reg.rdata;
  assign PIN_OUT           = st_reg.pin_o;
  assign PIN_OE_OUT        = st_reg.pin_oe;
  assign WAKE_REQ_OUT      = st_reg.wake;
  assign CONV_START_OUT    = st_reg.conv_go;
  assign SEQ_START_OUT     = st_reg.seq_go;
  assign RESULT_TARGET_OUT = st_reg.cfg.dest;
  assign CONV_KIND_OUT     = st_reg.cfg.kind;
  assign SEQ_ENTRY_OUT     = st_reg.cfg.entry;

  // Checks on the logic above
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (RST_IN);

  sequence s_edge_awake;
    rise && trig_en && !asleep && st_reg.fsm == GTC_FSM_IDLE;
  endsequence

  sequence s_edge_asleep;
    rise && trig_en && asleep && st_reg.fsm == GTC_FSM_IDLE;
  endsequence

  sequence s_woken;
    st_reg.wake && !asleep;
  endsequence

  a_reserved_write_drop: assert property (
    wr_ctrl && !ctrl_ok |=> $stable({st_reg.dir, st_reg.isel, st_reg.osel}))
    else $error("reserved pin control write changed fields");

  a_ctrl_write_store: assert property (
    wr_ctrl && ctrl_ok |=> st_reg.dir == $past(w_dir) && st_reg.osel == $past(w_osel))
    else $error("legal pin control write not stored");

  a_edge_conv_start: assert property (
    s_edge_awake ##0 st_reg.isel == GTC_IN_CONV |=> CONV_START_OUT && !SEQ_START_OUT)
    else $error("awake conversion edge gave no start");

  a_output_no_trigger: assert property (
    st_reg.dir != GTC_DIR_INPUT && st_reg.fsm == GTC_FSM_IDLE
      |=> !CONV_START_OUT && !SEQ_START_OUT)
    else $error("trigger fired while pin is an output");

  a_wake_before_start: assert property (
    s_edge_asleep |=> WAKE_REQ_OUT && !CONV_START_OUT && !SEQ_START_OUT)
    else $error("start issued before wake");

  a_wake_then_go: assert property (
    s_woken |=> !WAKE_REQ_OUT && (CONV_START_OUT != SEQ_START_OUT))
    else $error("no start after wake completed");

  a_drive_low_const: assert property (
    st_reg.dir == GTC_DIR_CMOS && st_reg.osel == GTC_OUT_LOW |=> PIN_OE_OUT && !PIN_OUT)
    else $error("constant low not driven");

  a_irq_polarity: assert property (
    st_reg.dir == GTC_DIR_CMOS && st_reg.osel == GTC_OUT_IRQN |=> PIN_OUT == !$past(IRQ_IN))
    else $error("active-low interrupt wrong level");

  a_open_drain_low: assert property (
    st_reg.dir == GTC_DIR_OPEN && st_reg.osel != GTC_OUT_HIZ |=> !(PIN_OE_OUT && PIN_OUT))
    else $error("open-drain pin driven high");

  a_conv_write_quiet: assert property (
    wr_conv && !rise && st_reg.fsm == GTC_FSM_IDLE |=> !CONV_START_OUT)
    else $error("config write started a conversion");

  a_entry_range: assert property (
    wr_entry && !entry_ok |=> $stable(SEQ_ENTRY_OUT))
    else $error("out-of-range entry accepted");

  a_single_start: assert property (
    CONV_START_OUT || SEQ_START_OUT |=> !CONV_START_OUT && !SEQ_START_OUT)
    else $error("start request longer than one cycle");

  // Clock code held on a push-pull pin
  sequence s_clock_out;
    st_reg.dir == GTC_DIR_CMOS && st_reg.osel == GTC_OUT_CLK;
  endsequence

  a_isel_store: assert property (
    wr_ctrl && ctrl_ok |=> st_reg.isel == $past(w_isel))
    else $error("legal input function not stored");

  a_edge_seq_start: assert property (
    s_edge_awake ##0 st_reg.isel == GTC_IN_SEQ |=> SEQ_START_OUT && !CONV_START_OUT)
    else $error("awake sequence edge gave no start");

  a_wake_hold: assert property (
    WAKE_REQ_OUT && asleep |=> WAKE_REQ_OUT && !CONV_START_OUT && !SEQ_START_OUT)
    else $error("start issued while still in low power");

  a_input_no_drive: assert property (
    st_reg.dir == GTC_DIR_INPUT |=> !PIN_OE_OUT)
    else $error("input pin driven");

  a_hiz_release: assert property (
    st_reg.osel == GTC_OUT_HIZ |=> !PIN_OE_OUT)
    else $error("high impedance code drove the pin");

  a_cmos_drive: assert property (
    st_reg.dir == GTC_DIR_CMOS && st_reg.osel != GTC_OUT_HIZ && st_reg.osel != GTC_OUT_LSW
      |=> PIN_OE_OUT)
    else $error("push-pull output not driven");

  a_irq_high_level: assert property (
    st_reg.dir == GTC_DIR_CMOS && st_reg.osel == GTC_OUT_IRQ |=> PIN_OUT == $past(IRQ_IN))
    else $error("active-high interrupt wrong level");

  a_clock_out_toggle: assert property (
    s_clock_out ##1 s_clock_out |=> $changed(PIN_OUT))
    else $error("clock output did not toggle");

  a_mod_status_out: assert property (
    st_reg.dir == GTC_DIR_CMOS && st_reg.osel == GTC_OUT_MOD
      |=> PIN_OUT == $past(MOD_ACTIVE_IN))
    else $error("modulator status not on pin");

  a_low_side_switch: assert property (
    st_reg.dir != GTC_DIR_INPUT && st_reg.osel == GTC_OUT_LSW
      |=> !PIN_OUT && PIN_OE_OUT == $past(LOW_SIDE_SW_IN))
    else $error("low-side switch not followed");

  a_dest_store: assert property (
    wr_conv |=> RESULT_TARGET_OUT == $past(REG_WDATA_IN[`GTC_DEST_HI:`GTC_DEST_LO]))
    else $error("result target not stored");

  a_kind_store: assert property (
    wr_conv |=> CONV_KIND_OUT == $past(REG_WDATA_IN[`GTC_KIND_HI:`GTC_KIND_LO]))
    else $error("conversion kind not stored");

  a_entry_store: assert property (
    wr_entry && entry_ok |=> SEQ_ENTRY_OUT == $past(w_entry))
    else $error("legal entry address not stored");

  a_entry_write_quiet: assert property (
    wr_entry && !rise && st_reg.fsm == GTC_FSM_IDLE |=> !SEQ_START_OUT)
    else $error("entry write launched a sequence");

endmodule // gtc_top

// *** bench/gtc_far_side.sv ***
// Far-side model: trigger source on the pin and the device power manager
`timescale 1ns/1ns
module gtc_far_side
  import gtc_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       wake_in,
  output logic            pin_out,
  output logic      [1:0] pwr_out
);
  logic       pin_q    = 1'b0;
  logic [1:0] pwr_q    = 2'h0;
  logic [1:0] wake_cnt = 2'h0;
  logic [1:0] nap_want = 2'h0;
  int         nap_id   = 0;
  int         nap_seen = 0;

  // Idle pin low, device awake; each level has a single writer
  assign pin_out = pin_q;
  assign pwr_out = pwr_q;

  // One pulse, three clocks high so the edge is never missed
  task automatic fire();
    @(negedge clk_in);
    pin_q = 1'b1;
    repeat (3) @(negedge clk_in);
    pin_q = 1'b0;
    repeat (3) @(negedge clk_in);
  endtask

  // Ask the power manager for a power state
  task automatic nap(input gtc_pwr_t p);
    @(negedge clk_in);
    nap_want = p;
    nap_id++;
  endtask

  // Wake answered late on purpose, so an early start would show
  always @(negedge clk_in) begin
    if (nap_id != nap_seen) begin
      nap_seen = nap_id;
      pwr_q    = nap_want;
      wake_cnt = 2'h0;
    end else if (wake_in && pwr_q != GTC_PWR_NORMAL) begin
      wake_cnt = wake_cnt + 2'h1;
      if (wake_cnt == 2'h3) pwr_q = GTC_PWR_NORMAL;
    end else begin
      wake_cnt = 2'h0;
    end
  end
endmodule // gtc_far_side

// *** bench/gtc_top_test.sv ***
// Self-checking bench of the pin trigger configuration block
`timescale 1ns/1ns
module gtc_top_test
  import gtc_pkg::*;
;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       wr = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic       pin;
  logic       pin_o;
  logic       pin_oe;
  logic [1:0] pwr;
  logic       wake;
  logic       conv;
  logic       seq;
  logic [2:0] target;
  logic [1:0] kind;
  logic [6:0] entry;
  logic [6:0] seq_at = 7'h00;
  int         n_conv = 0;
  int         n_seq = 0;
  int         woke = 0;
  int         bad_order = 0;
  int         err_total = 0;
  int         tests_run = 0;
  logic       prev;
  logic       irq = 1'b1;
  logic       mod = 1'b0;
  logic       lsw = 1'b1;

  always #20 clk = ~clk;

  gtc_top dut (.CLOCK_IN(clk), .RST_IN(rst), .REG_WR_IN(wr), .REG_ADDR_IN(addr),
    .REG_WDATA_IN(wdata), .REG_RDATA_OUT(rdata), .PIN_IN(pin), .PIN_OUT(pin_o),
    .PIN_OE_OUT(pin_oe), .IRQ_IN(irq), .MOD_ACTIVE_IN(mod), .LOW_SIDE_SW_IN(lsw),
    .POWER_STATE_IN(pwr), .WAKE_REQ_OUT(wake), .CONV_START_OUT(conv),
    .SEQ_START_OUT(seq), .RESULT_TARGET_OUT(target), .CONV_KIND_OUT(kind),
    .SEQ_ENTRY_OUT(entry));

  gtc_far_side far (.clk_in(clk), .wake_in(wake), .pin_out(pin), .pwr_out(pwr));

  // Count start pulses; a start while still asleep is an ordering fault
  always @(posedge clk) begin
    if (conv === 1'b1) n_conv++;
    if (seq === 1'b1) begin
      n_seq++;
      seq_at = entry;
    end
    if (wake === 1'b1) woke = 1;
    if ((conv === 1'b1 || seq === 1'b1) && pwr !== GTC_PWR_NORMAL) bad_order++;
  end

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask

  task automatic st(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic wrr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    wr = 1'b1;
    addr = a;
    wdata = d;
    @(negedge clk);
    wr = 1'b0;
  endtask

  // Read data is registered, so look one edge after the address
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    addr = a;
    @(negedge clk);
    chk("rdata", exp, rdata);
  endtask

  task automatic print_verdict();
    if (err_total == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Whole run takes well under a thousand clocks
  initial begin
    repeat (4000) @(posedge clk);
    err_total++;
    print_verdict();
  end

  // Expected pin level per output code with irq high, modulator idle
  localparam logic [7:0] OUT_EXP = 8'h14;

  initial begin
    repeat (8) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    chk("entry", 8'h3a, {1'b0, entry});
    rd(8'h05, 8'h00);
    rd(8'h06, 8'h00);
    rd(8'h07, 8'h3a);
    rd(8'h10, 8'h00);
    wrr(8'h05, 8'h40);
    rd(8'h05, 8'h00);
    wrr(8'h05, 8'h30);
    rd(8'h05, 8'h00);
    for (int o = 0; o < 8; o++) begin
      wrr(8'h05, {5'b11000, 3'(o)});
      st(2);
      chk("oe", {7'h00, o != 0}, {7'h00, pin_oe});
      if (o != 0 && o != 5) chk("out", {7'h00, OUT_EXP[o]}, {7'h00, pin_o});
      prev = pin_o;
      st(1);
      if (o == 5) chk("clk", {7'h00, ~prev}, {7'h00, pin_o});
    end
    // Flip the live inputs so stuck outputs cannot pass
    irq = 1'b0;
    mod = 1'b1;
    lsw = 1'b0;
    wrr(8'h05, 8'hc1);
    st(2);
    chk("irqn", 8'h01, {7'h00, pin_o});
    wrr(8'h05, 8'hc2);
    st(2);
    chk("irq", 8'h00, {7'h00, pin_o});
    wrr(8'h05, 8'hc6);
    st(2);
    chk("mod", 8'h01, {7'h00, pin_o});
    wrr(8'h05, 8'hc7);
    st(2);
    chk("lsw", 8'h00, {6'h00, pin_o, pin_oe});
    // Open drain drives only a low level
    wrr(8'h05, 8'h84);
    st(2);
    chk("od hi", 8'h00, {7'h00, pin_oe});
    wrr(8'h05, 8'h83);
    st(2);
    chk("od lo", 8'h01, {6'h00, pin_o, pin_oe});
    wrr(8'h05, 8'h04);
    st(2);
    chk("in oe", 8'h00, {7'h00, pin_oe});
    for (int k = 0; k < 4; k++) begin
      wrr(8'h06, {1'b0, 3'(7 - k), 2'b00, 2'(k)});
      st(1);
      chk("cfg", {1'b0, 3'(7 - k), 2'b00, 2'(k)}, {1'b0, target, 2'b00, kind});
    end
    rd(8'h06, 8'h43);
    wrr(8'h07, 8'h39);
    rd(8'h07, 8'h3a);
    wrr(8'h07, 8'h70);
    rd(8'h07, 8'h3a);
    wrr(8'h07, 8'h6f);
    rd(8'h07, 8'h6f);
    chk("no start", 8'h00, 8'(n_conv + n_seq));
    wrr(8'h05, 8'hd0);
    far.fire();
    st(4);
    chk("out dir", 8'h00, 8'(n_conv));
    wrr(8'h05, 8'h10);
    far.fire();
    st(4);
    chk("conv", 8'h01, 8'(n_conv));
    wrr(8'h05, 8'h20);
    far.fire();
    st(4);
    chk("seq", 8'h01, 8'(n_seq));
    chk("seq at", 8'h6f, {1'b0, seq_at});
    wrr(8'h05, 8'h00);
    far.fire();
    st(4);
    chk("off", 8'h02, 8'(n_conv + n_seq));
    wrr(8'h05, 8'h10);
    far.nap(GTC_PWR_SLEEP);
    far.fire();
    st(10);
    chk("sleep", 8'h12, {3'h0, 1'(woke), 4'(n_conv)});
    wrr(8'h05, 8'h20);
    far.nap(GTC_PWR_STANDBY);
    far.fire();
    st(10);
    chk("standby", 8'h02, 8'(n_seq));
    chk("order", 8'h00, 8'(bad_order));
    // Reset in mid-run returns every field to its reset value
    @(negedge clk);
    rst = 1'b1;
    st(2);
    rst = 1'b0;
    chk("rst out", 8'h00, {2'h0, target, kind, pin_oe});
    chk("rst entry", 8'h3a, {1'b0, entry});
    rd(8'h05, 8'h00);
    rd(8'h07, 8'h3a);
    print_verdict();
  end
endmodule // gtc_top_test
